/* host_port_irq_routing.sv */
// Host-port interrupt routing, breakpoint, message flags and mailbox
//
// Summary of operation
// - 16-bit breakpoint register: host reads and writes, CPU only reads.
// - Host breakpoint behaves like the CPU's own breakpoint register.
// - Program counter equal to a non-zero stored address raises breakpoint interrupt 127.
// - Routing register host-writable; routed interrupts drive host line and status port.
// - Routing selects destination only; engine enable register still gates each interrupt.
// - Bit 15 routes bus-voltage, bit 14 routes ID-pin interrupt to host.
// - Bit 9 routes engine 2 bus reset, bit 1 engine 1 bus reset.
// - Bit 7 routes host engine 2 resume, bit 6 host engine 1 resume.
// - Bit 3 routes engine 2 done, bit 2 engine 1 done interrupt.
// - Engine 2 frame interrupt: bit 13 to host, bit 12 to CPU, independent.
// - Engine 1 frame interrupt: bit 11 to host, bit 10 to CPU, independent.
// - Swap 00 keeps default lane order; 11 exchanges the two byte lanes.
// - A CPU write to an engine message register sets its status flag; host writes do not.
// - A set message flag with its enable set asserts the host line.
// - Host read of a message register clears its flag.
// - Host mailbox write raises receive-full; CPU mailbox read clears it.
// - CPU mailbox write asserts host line; host read clears it, raises transmit-empty.
// - Message flags for engines 2 and 1 sit at status bits 5 and 4.
`timescale 1ns/1ps
`default_nettype none

module host_port_irq_routing (
  input  wire logic                                  mclk,
  input  wire logic                                  rst_n,
  input  wire logic                                  clkEnable,
  // Host port access, already in the mclk domain
  input  wire host_port_irq_pkg::mem_access_type     hostAccess,
  output var  logic [15:0]                           hostReadData,
  input  wire logic                                  hostStatusRead,
  output var  logic [15:0]                           hostStatus,
  output var  logic                                  hostIrqLine,
  // On-chip CPU access
  input  wire host_port_irq_pkg::mem_access_type     cpuAccess,
  output var  logic [15:0]                           cpuReadData,
  input  wire logic [15:0]                           programCounter,
  output var  logic                                  breakpointInterrupt,
  output var  logic [6:0]                            breakpointVector,
  // Engine interrupts and their enables
  input  wire host_port_irq_pkg::engine_irq_type     engineIrq,
  input  wire host_port_irq_pkg::engine_irq_type     engineIrqEnable,
  input  wire logic [1:0]                            messageIrqEnable,
  input  wire logic                                  mailboxRxEnable,
  input  wire logic                                  mailboxTxEnable,
  output var  host_port_irq_pkg::engine_irq_type     cpuEngineIrq,
  output var  logic                                  mailboxRxFullIrq,
  output var  logic                                  mailboxTxEmptyIrq,
  output var  logic                                  byteSwapHigh,
  output var  logic                                  byteSwapLow
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic hostWrBreak;
  logic hostWrRoute;
  logic hostWrMbox;
  logic hostRdMbox;
  logic cpuWrMbox;
  logic cpuRdMbox;
  logic [1:0] cpuWrMsg;
  logic [1:0] hostRdMsg;

  // Strobes for each register and party
  assign hostWrBreak = hostAccess.wr &&
                       hostAccess.addr == host_port_irq_pkg::HOST_BREAKPOINT_ADDRESS_OFFSET;
  assign hostWrRoute = hostAccess.wr &&
                       hostAccess.addr == host_port_irq_pkg::INTERRUPT_ROUTE_CONTROL_OFFSET;
  assign hostWrMbox  = hostAccess.wr &&
                       hostAccess.addr == host_port_irq_pkg::HOST_CPU_MAILBOX_OFFSET;
  assign hostRdMbox  = hostAccess.rd &&
                       hostAccess.addr == host_port_irq_pkg::HOST_CPU_MAILBOX_OFFSET;
  assign cpuWrMbox   = cpuAccess.wr &&
                       cpuAccess.addr == host_port_irq_pkg::HOST_CPU_MAILBOX_OFFSET;
  assign cpuRdMbox   = cpuAccess.rd &&
                       cpuAccess.addr == host_port_irq_pkg::HOST_CPU_MAILBOX_OFFSET;
  assign cpuWrMsg[0] = cpuAccess.wr &&
                       cpuAccess.addr == host_port_irq_pkg::ENGINE1_MESSAGE_OFFSET;
  assign cpuWrMsg[1] = cpuAccess.wr &&
                       cpuAccess.addr == host_port_irq_pkg::ENGINE2_MESSAGE_OFFSET;
  assign hostRdMsg[0] = hostAccess.rd &&
                        hostAccess.addr == host_port_irq_pkg::ENGINE1_MESSAGE_OFFSET;
  assign hostRdMsg[1] = hostAccess.rd &&
                        hostAccess.addr == host_port_irq_pkg::ENGINE2_MESSAGE_OFFSET;

  // ----------------------------------------------------------------------
  // Breakpoint register
  // ----------------------------------------------------------------------
  logic [15:0] breakpoint_reg;
  logic        breakHit_reg;

  // Only the host port may write; CPU writes are ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      breakpoint_reg <= host_port_irq_pkg::BREAKPOINT_RESET;
    end else if (clkEnable && hostWrBreak) begin
      breakpoint_reg <= hostAccess.wdata;
    end
  end

  // PC match raises the breakpoint interrupt, winning over a same-cycle clear; zero disarms
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      breakHit_reg <= 1'b0;
    end else if (clkEnable) begin
      if (breakpoint_reg != 16'h0000 && programCounter == breakpoint_reg) begin
        breakHit_reg <= 1'b1;
      end else if (hostWrBreak && hostAccess.wdata == 16'h0000) begin
        breakHit_reg <= 1'b0;
      end
    end
  end

  assign breakpointInterrupt = breakHit_reg;
  assign breakpointVector    = host_port_irq_pkg::BREAKPOINT_VECTOR;

  // ----------------------------------------------------------------------
  // Routing register
  // ----------------------------------------------------------------------
  logic [15:0] route_reg;

  // Host-writable, CPU read-only; reserved bits stay zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      route_reg <= host_port_irq_pkg::ROUTE_RESET;
    end else if (clkEnable && hostWrRoute) begin
      route_reg <= hostAccess.wdata & host_port_irq_pkg::ROUTE_WRITABLE_MASK;
    end
  end

  // Byte-swap selectors; host keeps both bits equal
  assign byteSwapHigh = route_reg[host_port_irq_pkg::ROUTE_SWAP_HIGH];
  assign byteSwapLow  = route_reg[host_port_irq_pkg::ROUTE_SWAP_LOW];

  // ----------------------------------------------------------------------
  // Interrupt steering
  // ----------------------------------------------------------------------
  logic [15:0] enabledIrq;
  logic [15:0] hostRouted;
  logic [15:0] cpuRouted;

  // Enable gates each interrupt independent of where it goes
  assign enabledIrq = engineIrq & engineIrqEnable;

  // Exclusive routes: set bit sends to host, clear bit leaves on CPU
  always_comb begin
    hostRouted = enabledIrq & route_reg & host_port_irq_pkg::EXCLUSIVE_ROUTE_MASK;
    cpuRouted  = enabledIrq & ~route_reg & host_port_irq_pkg::EXCLUSIVE_ROUTE_MASK;
    // Frame interrupts have separate host and CPU enables
    hostRouted[host_port_irq_pkg::ROUTE_FRAME2_HOST] =
      enabledIrq[host_port_irq_pkg::ROUTE_FRAME2_HOST] &
      route_reg[host_port_irq_pkg::ROUTE_FRAME2_HOST];
    cpuRouted[host_port_irq_pkg::ROUTE_FRAME2_HOST] =
      enabledIrq[host_port_irq_pkg::ROUTE_FRAME2_HOST] &
      route_reg[host_port_irq_pkg::ROUTE_FRAME2_CPU];
    hostRouted[host_port_irq_pkg::ROUTE_FRAME1_HOST] =
      enabledIrq[host_port_irq_pkg::ROUTE_FRAME1_HOST] &
      route_reg[host_port_irq_pkg::ROUTE_FRAME1_HOST];
    cpuRouted[host_port_irq_pkg::ROUTE_FRAME1_HOST] =
      enabledIrq[host_port_irq_pkg::ROUTE_FRAME1_HOST] &
      route_reg[host_port_irq_pkg::ROUTE_FRAME1_CPU];
  end

  assign cpuEngineIrq = cpuRouted;

  // ----------------------------------------------------------------------
  // Engine message flags
  // ----------------------------------------------------------------------
  logic [1:0] msgFlag_reg;

  // One flag per message channel; a CPU write sets, a host read clears, set wins
  generate
    for (genvar ch = 0; ch < host_port_irq_pkg::MSG_CHANNELS; ch++) begin : gMsg
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          msgFlag_reg[ch] <= 1'b0;
        end else if (clkEnable) begin
          if (cpuWrMsg[ch]) begin
            msgFlag_reg[ch] <= 1'b1;
          end else if (hostRdMsg[ch]) begin
            msgFlag_reg[ch] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Mailbox
  // ----------------------------------------------------------------------
  logic [15:0] mailbox_reg;
  logic        mailboxIn_reg;
  logic        mailboxOut_reg;
  logic        txEmpty_reg;

  // Shared word; CPU write takes priority when both write together
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mailbox_reg <= host_port_irq_pkg::MAILBOX_RESET;
    end else if (clkEnable) begin
      if (cpuWrMbox) begin
        mailbox_reg <= cpuAccess.wdata;
      end else if (hostWrMbox) begin
        mailbox_reg <= hostAccess.wdata;
      end
    end
  end

  // Receive-full: set by host write, cleared by CPU read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mailboxIn_reg <= 1'b0;
    end else if (clkEnable) begin
      if (hostWrMbox) begin
        mailboxIn_reg <= 1'b1;
      end else if (cpuRdMbox) begin
        mailboxIn_reg <= 1'b0;
      end
    end
  end

  // Mailbox-out pending: set by CPU write, cleared by host read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mailboxOut_reg <= 1'b0;
    end else if (clkEnable) begin
      if (cpuWrMbox) begin
        mailboxOut_reg <= 1'b1;
      end else if (hostRdMbox) begin
        mailboxOut_reg <= 1'b0;
      end
    end
  end

  // Transmit-empty: set by host read, cleared by CPU write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txEmpty_reg <= 1'b0;
    end else if (clkEnable) begin
      if (hostRdMbox) begin
        txEmpty_reg <= 1'b1;
      end else if (cpuWrMbox) begin
        txEmpty_reg <= 1'b0;
      end
    end
  end

  assign mailboxRxFullIrq  = mailboxIn_reg & mailboxRxEnable;
  assign mailboxTxEmptyIrq = txEmpty_reg & mailboxTxEnable;

  // ----------------------------------------------------------------------
  // Host status port and interrupt line
  // ----------------------------------------------------------------------
  logic [15:0] status_next;
  logic [15:0] status_reg;
  logic        irq_next;
  logic        irq_reg;

  // Routed interrupts at their own positions, frame interrupts one bit lower, then mailbox and message flags
  always_comb begin
    status_next = hostRouted;
    status_next[host_port_irq_pkg::ROUTE_FRAME2_CPU] =
      hostRouted[host_port_irq_pkg::ROUTE_FRAME2_HOST];
    status_next[host_port_irq_pkg::ROUTE_FRAME1_CPU] =
      hostRouted[host_port_irq_pkg::ROUTE_FRAME1_HOST];
    status_next[host_port_irq_pkg::ROUTE_FRAME2_HOST] = 1'b0;
    status_next[host_port_irq_pkg::ROUTE_FRAME1_HOST] = 1'b0;
    status_next[host_port_irq_pkg::STATUS_MAILBOX_IN]  = mailboxIn_reg;
    status_next[host_port_irq_pkg::STATUS_MSG2_BIT]    = msgFlag_reg[1];
    status_next[host_port_irq_pkg::STATUS_MSG1_BIT]    = msgFlag_reg[0];
    status_next[host_port_irq_pkg::STATUS_MAILBOX_OUT] = mailboxOut_reg;
    irq_next = (|hostRouted) | (|(msgFlag_reg & messageIrqEnable)) | mailboxOut_reg;
  end

  // Registered status word and host interrupt line
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 16'h0000;
      irq_reg    <= 1'b0;
    end else if (clkEnable) begin
      status_reg <= status_next;
      irq_reg    <= irq_next;
    end
  end

  assign hostStatus  = status_reg;
  assign hostIrqLine = irq_reg;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [15:0] hostWord;
  logic [15:0] hostSwapped;
  logic [15:0] hostRead_reg;
  logic [15:0] cpuRead_reg;

  // Host-visible registers; message registers are write-only and read zero
  always_comb begin
    case (hostAccess.addr)
      host_port_irq_pkg::HOST_BREAKPOINT_ADDRESS_OFFSET: hostWord = breakpoint_reg;
      host_port_irq_pkg::INTERRUPT_ROUTE_CONTROL_OFFSET: hostWord = route_reg;
      host_port_irq_pkg::HOST_CPU_MAILBOX_OFFSET:        hostWord = mailbox_reg;
      default:                                           hostWord = 16'h0000;
    endcase
  end

  // Swapped lanes only when both swap bits are set
  byte_lane_swap uSwap (
    .swapEnable (byteSwapHigh & byteSwapLow),
    .wordIn     (hostWord),
    .wordOut    (hostSwapped)
  );

  // Host read data is captured on a read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hostRead_reg <= 16'h0000;
    end else if (clkEnable && hostAccess.rd) begin
      hostRead_reg <= hostSwapped;
    end
  end

  // CPU sees breakpoint and routing as read-only, mailbox as read-write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRead_reg <= 16'h0000;
    end else if (clkEnable && cpuAccess.rd) begin
      case (cpuAccess.addr)
        host_port_irq_pkg::HOST_BREAKPOINT_ADDRESS_OFFSET: cpuRead_reg <= breakpoint_reg;
        host_port_irq_pkg::INTERRUPT_ROUTE_CONTROL_OFFSET: cpuRead_reg <= route_reg;
        host_port_irq_pkg::HOST_CPU_MAILBOX_OFFSET:        cpuRead_reg <= mailbox_reg;
        default:                                           cpuRead_reg <= 16'h0000;
      endcase
    end
  end

  assign hostReadData = hostRead_reg;
  assign cpuReadData  = cpuRead_reg;

  // Status is always live; the strobe carries no side effect on the CPU
  logic unusedStatusRead;
  assign unusedStatusRead = hostStatusRead;

endmodule // host_port_irq_routing

`default_nettype wire

/* host_port_irq_pkg.sv */
// Package: offsets, field positions, reset values and carrier types of the host-port interrupt block
package host_port_irq_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses on the on-chip memory map)
  // ----------------------------------------------------------------------
  localparam logic [15:0] HOST_BREAKPOINT_ADDRESS_OFFSET = 16'h0140;
  localparam logic [15:0] INTERRUPT_ROUTE_CONTROL_OFFSET = 16'h0142;
  localparam logic [15:0] ENGINE1_MESSAGE_OFFSET         = 16'h0144;
  localparam logic [15:0] ENGINE2_MESSAGE_OFFSET         = 16'h0148;
  localparam logic [15:0] HOST_CPU_MAILBOX_OFFSET        = 16'hc0c6;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] BREAKPOINT_RESET = 16'h0000;
  localparam logic [15:0] ROUTE_RESET      = 16'h1400;
  localparam logic [15:0] MAILBOX_RESET    = 16'h0000;

  // Interrupt vector raised on a breakpoint hit
  localparam logic [6:0]  BREAKPOINT_VECTOR = 7'h7f;

  // ----------------------------------------------------------------------
  // Routing register bit positions
  // ----------------------------------------------------------------------
  localparam int ROUTE_VBUS_BIT       = 15;
  localparam int ROUTE_ID_BIT         = 14;
  localparam int ROUTE_FRAME2_HOST    = 13;
  localparam int ROUTE_FRAME2_CPU     = 12;
  localparam int ROUTE_FRAME1_HOST    = 11;
  localparam int ROUTE_FRAME1_CPU     = 10;
  localparam int ROUTE_RESET2_BIT     = 9;
  localparam int ROUTE_SWAP_HIGH      = 8;
  localparam int ROUTE_RESUME2_BIT    = 7;
  localparam int ROUTE_RESUME1_BIT    = 6;
  localparam int ROUTE_DONE2_BIT      = 3;
  localparam int ROUTE_DONE1_BIT      = 2;
  localparam int ROUTE_RESET1_BIT     = 1;
  localparam int ROUTE_SWAP_LOW       = 0;

  // Routing bits that move an interrupt from CPU to host (exclusive routes)
  localparam logic [15:0] EXCLUSIVE_ROUTE_MASK = 16'hc2ce;
  // Reserved routing bits read as zero
  localparam logic [15:0] ROUTE_WRITABLE_MASK  = 16'hffcf;

  // ----------------------------------------------------------------------
  // Host status port bit positions
  // ----------------------------------------------------------------------
  localparam int STATUS_MAILBOX_IN  = 8;
  localparam int STATUS_MSG2_BIT    = 5;
  localparam int STATUS_MSG1_BIT    = 4;
  localparam int STATUS_MAILBOX_OUT = 0;

  // Number of engine message channels
  localparam int MSG_CHANNELS = 2;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  // One memory access from either the host port or the on-chip CPU
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_access_type;

  // Raw interrupt requests from the USB engines, each bit at its routing position
  typedef logic [15:0] engine_irq_type;

endpackage : host_port_irq_pkg

/* byte_lane_swap.sv */
// Byte-lane ordering for the 16-bit host data bus
`timescale 1ns/1ps
`default_nettype none

module byte_lane_swap (
  input  wire logic        swapEnable,
  input  wire logic [15:0] wordIn,
  output var  logic [15:0] wordOut
);

  // Exchange the two byte lanes when swapping is selected
  always_comb begin
    if (swapEnable) begin
      wordOut = {wordIn[7:0], wordIn[15:8]};
    end else begin
      wordOut = wordIn;
    end
  end

endmodule // byte_lane_swap

`default_nettype wire

/* host_port_irq_routing_props.sv */
// Concurrent checks on the ports of the host-port interrupt block
`timescale 1ns/1ps
`default_nettype none

module host_port_irq_routing_props (
  input wire logic                              mclk,
  input wire logic                              rst_n,
  input wire logic                              clkEnable,
  input wire host_port_irq_pkg::mem_access_type hostAccess,
  input wire logic [15:0]                       hostStatus,
  input wire logic                              hostIrqLine,
  input wire host_port_irq_pkg::mem_access_type cpuAccess,
  input wire logic [15:0]                       programCounter,
  input wire logic                              breakpointInterrupt,
  input wire logic [6:0]                        breakpointVector,
  input wire host_port_irq_pkg::engine_irq_type engineIrq,
  input wire host_port_irq_pkg::engine_irq_type engineIrqEnable,
  input wire host_port_irq_pkg::engine_irq_type cpuEngineIrq,
  input wire logic                              mailboxRxEnable,
  input wire logic                              mailboxRxFullIrq
);
  logic [15:0] bpShadowReg;

  // ----------------------------------------------------------------
  // Shadow of the host breakpoint address
  // ----------------------------------------------------------------
  // Only host writes load it, so CPU writes must leave the match alone
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bpShadowReg <= 16'h0000;
    end else if (clkEnable && hostAccess.wr && hostAccess.addr == 16'h0140) begin
      bpShadowReg <= hostAccess.wdata;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_vector;
    breakpointVector == 7'h7f;
  endproperty
  a_vector: assert property (p_vector) else $error("breakpoint vector wrong");

  property p_bp_hit;
    clkEnable && bpShadowReg != 16'h0000 && programCounter == bpShadowReg |=> breakpointInterrupt;
  endproperty
  a_bp_hit: assert property (p_bp_hit) else $error("breakpoint hit missed");

  property p_bp_clear;
    clkEnable && hostAccess.wr && hostAccess.addr == 16'h0140 && hostAccess.wdata == 16'h0000
      && programCounter != bpShadowReg |-> ##[1:2] !breakpointInterrupt;
  endproperty
  a_bp_clear: assert property (p_bp_clear) else $error("breakpoint not cleared");

  property p_msg_set;
    clkEnable && cpuAccess.wr && cpuAccess.addr == 16'h0144 |-> ##2 hostStatus[4];
  endproperty
  a_msg_set: assert property (p_msg_set) else $error("message flag not set");

  property p_msg_clear;
    clkEnable && hostAccess.rd && hostAccess.addr == 16'h0148
      && !(cpuAccess.wr && cpuAccess.addr == 16'h0148) |-> ##2 !hostStatus[5];
  endproperty
  a_msg_clear: assert property (p_msg_clear) else $error("message flag not cleared");

  property p_mb_out;
    clkEnable && cpuAccess.wr && cpuAccess.addr == 16'hc0c6 |-> ##2 (hostIrqLine && hostStatus[0]);
  endproperty
  a_mb_out: assert property (p_mb_out) else $error("mailbox out not signalled");

  property p_mb_rx;
    clkEnable && hostAccess.wr && hostAccess.addr == 16'hc0c6 |=> mailboxRxFullIrq || !mailboxRxEnable;
  endproperty
  a_mb_rx: assert property (p_mb_rx) else $error("mailbox receive not raised");

  property p_cpu_gate;
    (cpuEngineIrq & ~(engineIrq & engineIrqEnable)) == 16'h0000;
  endproperty
  a_cpu_gate: assert property (p_cpu_gate) else $error("disabled interrupt reached cpu");
endmodule // host_port_irq_routing_props

bind host_port_irq_routing host_port_irq_routing_props i_props (
  .mclk, .rst_n, .clkEnable, .hostAccess, .hostStatus, .hostIrqLine, .cpuAccess,
  .programCounter, .breakpointInterrupt, .breakpointVector, .engineIrq, .engineIrqEnable,
  .cpuEngineIrq, .mailboxRxEnable, .mailboxRxFullIrq);

`default_nettype wire

/* host_port_model.sv */
// Access master model for the host port, also reused for the CPU side
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
  input  wire logic [15:0]                       hostReadData,
  input  wire logic                              mclk,
  output var  host_port_irq_pkg::mem_access_type hostAccess
);
  // Idle bus at time zero
  initial hostAccess = '0;

  // One access: strobe for one edge, then idle with inverted address and data
  task automatic cycle(input logic rd, input logic [15:0] addr, input logic [15:0] wdata,
                       output logic [15:0] rdata);
    @(posedge mclk);
    hostAccess <= {rd, ~rd, addr, wdata};
    @(posedge mclk);
    hostAccess <= {1'b0, 1'b0, ~addr, ~wdata};
    @(posedge mclk);
    rdata = hostReadData;
  endtask
endmodule // host_port_model

`default_nettype wire

/* test_host_port_irq_routing.sv */
// Self-checking bench for the host-port interrupt block
`timescale 1ns/1ps
`default_nettype none

module test_host_port_irq_routing;
  logic                              mclk;
  logic                              rst_n;
  logic                              clkEnable;
  logic                              hostStatusRead;
  host_port_irq_pkg::mem_access_type hostAccess;
  host_port_irq_pkg::mem_access_type cpuAccess;
  host_port_irq_pkg::engine_irq_type engineIrq;
  host_port_irq_pkg::engine_irq_type engineIrqEnable;
  host_port_irq_pkg::engine_irq_type cpuEngineIrq;
  logic [15:0]                       hostReadData;
  logic [15:0]                       cpuReadData;
  logic [15:0]                       hostStatus;
  logic [15:0]                       programCounter;
  logic [1:0]                        messageIrqEnable;
  logic [6:0]                        breakpointVector;
  logic hostIrqLine, breakpointInterrupt, mailboxRxEnable, mailboxTxEnable;
  logic mailboxRxFullIrq, mailboxTxEmptyIrq, byteSwapHigh, byteSwapLow;
  logic [15:0] rdat, v, r, m, ei, ee;
  logic [15:0] mbq[$];
  int errTotal, totalChecks, i;

  host_port_irq_routing i_host_port_irq_routing (
    .mclk, .rst_n, .clkEnable, .hostAccess, .hostReadData, .hostStatusRead, .hostStatus,
    .hostIrqLine, .cpuAccess, .cpuReadData, .programCounter, .breakpointInterrupt,
    .breakpointVector, .engineIrq, .engineIrqEnable, .messageIrqEnable, .mailboxRxEnable,
    .mailboxTxEnable, .cpuEngineIrq, .mailboxRxFullIrq, .mailboxTxEmptyIrq, .byteSwapHigh,
    .byteSwapLow);
  host_port_model hostSide (.mclk, .hostReadData, .hostAccess);
  host_port_model cpuSide (.mclk, .hostReadData(cpuReadData), .hostAccess(cpuAccess));

  // Clock at 125 MHz
  always #4 mclk = ~mclk;

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    if (errTotal == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One register access from either side; read data lands in rdat
  task automatic acc(input logic cpu, input logic rd, input logic [15:0] a, input logic [15:0] w);
    if (cpu) cpuSide.cycle(rd, a, w, rdat);
    else hostSide.cycle(rd, a, w, rdat);
  endtask

  // Interrupts left to the CPU for a given route and enabled request set
  function automatic logic [15:0] cpuExp(input logic [15:0] rt, input logic [15:0] a);
    return (a & ~rt & 16'hc2ce) | (a & {2'b00, rt[12], 1'b0, rt[10], 11'h000});
  endfunction

  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    errTotal++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    clkEnable = 1'b1;
    hostStatusRead = 1'b0;
    programCounter = 16'h0000;
    engineIrq = '0;
    engineIrqEnable = '0;
    messageIrqEnable = 2'h0;
    mailboxRxEnable = 1'b0;
    mailboxTxEnable = 1'b0;
    errTotal = 0;
    totalChecks = 0;
    void'($urandom(28132));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values and an unmapped read
    acc(1'b0, 1'b1, 16'h0140, 16'h0000);
    check(rdat, 16'h0000);
    acc(1'b1, 1'b1, 16'h0142, 16'h0000);
    check(rdat, 16'h1400);
    acc(1'b0, 1'b1, 16'h0200, 16'h0000);
    check(rdat, 16'h0000);
    check(breakpointVector, 7'h7f);
    // Breakpoint: host sets, CPU write ignored, match, clear by zero
    v = 16'($urandom) | 16'h0001;
    acc(1'b0, 1'b0, 16'h0140, v);
    acc(1'b1, 1'b0, 16'h0140, ~v);
    acc(1'b1, 1'b1, 16'h0140, 16'h0000);
    check(rdat, v);
    programCounter <= v;
    repeat (2) @(posedge mclk);
    check(breakpointInterrupt, 1'b1);
    programCounter <= ~v;
    acc(1'b0, 1'b0, 16'h0140, 16'h0000);
    @(posedge mclk);
    check(breakpointInterrupt, 1'b0);
    // Random routes, requests and enables
    for (i = 0; i < 24; i++) begin
      r = 16'($urandom);
      r[8] = i[0];
      r[0] = r[8];
      ei = 16'($urandom);
      ee = 16'($urandom);
      engineIrq <= ei;
      engineIrqEnable <= ee;
      acc(1'b0, 1'b0, 16'h0142, r);
      acc(1'b0, 1'b1, 16'h0142, 16'h0000);
      m = r & 16'hffcf;
      check(rdat, m[8] ? {m[7:0], m[15:8]} : m);
      check(cpuEngineIrq, cpuExp(m, ei & ee));
      check(hostIrqLine, |(ei & ee & m & 16'heace));
      check(hostStatus, (ei & ee & m & 16'hc2ce) | ((ei & ee & m) >> 1 & 16'h1400));
      check({byteSwapHigh, byteSwapLow}, {2{m[8]}});
    end
    engineIrq <= '0;
    acc(1'b0, 1'b0, 16'h0142, 16'h1400);
    // Message flags, only engine 1 enabled toward the host line
    messageIrqEnable <= 2'b01;
    for (i = 0; i < 2; i++) begin
      acc(1'b1, 1'b0, i ? 16'h0148 : 16'h0144, 16'($urandom));
      @(posedge mclk);
      check(hostStatus & 16'h0131, i ? 16'h0020 : 16'h0010);
      check(hostIrqLine, i == 0);
      acc(1'b0, 1'b1, i ? 16'h0148 : 16'h0144, 16'h0000);
      @(posedge mclk);
      check(hostStatus & 16'h0131, 16'h0000);
    end
    // Mailbox both directions
    mailboxRxEnable <= 1'b1;
    mailboxTxEnable <= 1'b1;
    mbq.push_back(16'($urandom));
    acc(1'b0, 1'b0, 16'hc0c6, mbq[0]);
    @(posedge mclk);
    check(mailboxRxFullIrq, 1'b1);
    check(hostStatus & 16'h0131, 16'h0100);
    acc(1'b1, 1'b1, 16'hc0c6, 16'h0000);
    check(rdat, mbq.pop_front());
    check(mailboxRxFullIrq, 1'b0);
    mbq.push_back(16'($urandom));
    acc(1'b1, 1'b0, 16'hc0c6, mbq[0]);
    @(posedge mclk);
    check(hostIrqLine, 1'b1);
    check(hostStatus & 16'h0131, 16'h0001);
    check(mailboxTxEmptyIrq, 1'b0);
    acc(1'b0, 1'b1, 16'hc0c6, 16'h0000);
    check(rdat, mbq.pop_front());
    @(posedge mclk);
    check(hostIrqLine, 1'b0);
    check(mailboxTxEmptyIrq, 1'b1);
    results();
  end
endmodule // test_host_port_irq_routing

`default_nettype wire
